// ---- sdl_consts.vh ----
`ifndef SDL_CONSTS_VH
`define SDL_CONSTS_VH
`define SDL_WORD_BITS 16
`define SDL_CODE_BITS 12
`define SDL_WORD_RST 16'h0000
`define SDL_CODE_RST 12'h000
`define SDL_BITCNT_RST 5'h00
`define SDL_BITCNT_LAST 5'h10
`define SDL_SYNC_RST 6'h1c
`define SDL_CLK_PERIOD_NS 20
`define SDL_LOAD_MIN_NS 50
`define SDL_LOAD_MIN_CYC ((`SDL_LOAD_MIN_NS + `SDL_CLK_PERIOD_NS - 1) / `SDL_CLK_PERIOD_NS)
`define SDL_FIFO_WIDTH 12
`define SDL_FIFO_DEPTH 4
`endif

// ---- sdl_fifo.v ----
`timescale 1ns/100ps
`default_nettype none
module sdl_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_wr;
    wire do_rd;
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // sdl_fifo
`default_nettype wire

// ---- sdl_word_loader.v ----
`include "sdl_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module sdl_word_loader (
    input wire sys_clk,
    input wire rst,
    input wire shift_clk,
    input wire shift_data,
    input wire frame_n,
    input wire latch_load_n,
    input wire latch_clear_n,
    input wire chain_enable,
    output reg serial_out,
    output reg [`SDL_CODE_BITS-1:0] dac_code,
    output reg dac_update,
    output reg [`SDL_CODE_BITS-1:0] code_data,
    output reg code_valid,
    input wire code_ready
);
    // Bit positions of each pin inside the synchroniser words
    localparam SYNC_CLK = 0;
    localparam SYNC_DATA = 1;
    localparam SYNC_FRAME = 2;
    localparam SYNC_LOAD = 3;
    localparam SYNC_CLEAR = 4;
    localparam SYNC_CHAIN = 5;

    // Two-stage synchronisers for every pin
    reg [5:0] sync1_reg;
    reg [5:0] sync2_reg;
    reg sclk_prev_reg;
    reg load_prev_reg;
    reg [`SDL_WORD_BITS-1:0] shift_reg;
    reg [4:0] bit_cnt_reg;
    reg [`SDL_CODE_BITS-1:0] latch_reg;
    reg upd_reg;
    wire s_clk;
    wire s_data;
    wire s_frame_n;
    wire s_load_n;
    wire s_clear_n;
    wire s_chain;
    wire sclk_fall;
    wire load_fall;
    wire auto_upd;
    wire strobe_upd;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`SDL_CODE_BITS-1:0] fifo_out_data;
    wire [`SDL_WORD_BITS-1:0] shift_next;

    // Falling edge of a synchronised pin, one sys_clk wide;
    // both detectors start at the idle level so a reset makes no edge
    function edge_fell;
        input prev;
        input now;
        begin
            edge_fell = prev && !now;
        end
    endfunction

    // Last bit of a 16-bit word; the counter wraps here
    function word_done;
        input [4:0] cnt;
        begin
            word_done = (cnt == `SDL_BITCNT_LAST - 5'h01);
        end
    endfunction

    // Code field of an input word;
    // the upper four bits are don't-care and never reach the latch
    function [`SDL_CODE_BITS-1:0] code_of;
        input [`SDL_WORD_BITS-1:0] w_in;
        begin
            code_of = w_in[`SDL_CODE_BITS-1:0];
        end
    endfunction

    // Queue head may take a new word when empty or being read
    function head_free;
        input valid;
        input ready;
        begin
            head_free = !valid || ready;
        end
    endfunction

    assign s_clk = sync2_reg[SYNC_CLK];
    assign s_data = sync2_reg[SYNC_DATA];
    assign s_frame_n = sync2_reg[SYNC_FRAME];
    assign s_load_n = sync2_reg[SYNC_LOAD];
    assign s_clear_n = sync2_reg[SYNC_CLEAR];
    assign s_chain = sync2_reg[SYNC_CHAIN];
    // Shift clock at 160 ns gives four system clocks per half period, enough to see each edge
    assign sclk_fall = edge_fell(sclk_prev_reg, s_clk);
    // Strobes shorter than the minimum width may be missed by the synchroniser
    assign load_fall = edge_fell(load_prev_reg, s_load_n);
    assign shift_next = {shift_reg[`SDL_WORD_BITS-2:0], s_data};
    // Automatic update on the sixteenth fall while latch load sits low
    assign auto_upd = sclk_fall && !s_frame_n && !s_load_n && word_done(bit_cnt_reg);
    assign strobe_upd = load_fall;

    always @(posedge sys_clk) begin
        if (rst) begin
            // Idle pin levels, so a release makes no false clear, frame or strobe
            sync1_reg <= `SDL_SYNC_RST;
            sync2_reg <= `SDL_SYNC_RST;
            sclk_prev_reg <= 1'b0;
            load_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= {chain_enable, latch_clear_n, latch_load_n, frame_n, shift_data,
                shift_clk};
            sync2_reg <= sync1_reg;
            sclk_prev_reg <= s_clk;
            load_prev_reg <= s_load_n;
        end
    end

    // Data sampled on falling shift-clock edges while frame is low
    always @(posedge sys_clk) begin
        if (rst) begin
            shift_reg <= `SDL_WORD_RST;
            bit_cnt_reg <= `SDL_BITCNT_RST;
        end else if (s_frame_n) begin
            bit_cnt_reg <= `SDL_BITCNT_RST;
        end else if (sclk_fall) begin
            shift_reg <= shift_next;
            // Counter wraps every word so chained frames keep counting
            if (word_done(bit_cnt_reg)) begin
                bit_cnt_reg <= `SDL_BITCNT_RST;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // Latch update; clear overrides and holds zero
    // Clear is a level, so the pulse stays high and the queue fills with zeros while it lasts
    always @(posedge sys_clk) begin
        if (rst) begin
            latch_reg <= `SDL_CODE_RST;
            upd_reg <= 1'b0;
        end else if (!s_clear_n) begin
            latch_reg <= `SDL_CODE_RST;
            upd_reg <= 1'b1;
        end else if (auto_upd) begin
            latch_reg <= code_of(shift_next);
            upd_reg <= 1'b1;
        end else if (strobe_upd) begin
            latch_reg <= code_of(shift_reg);
            upd_reg <= 1'b1;
        end else begin
            upd_reg <= 1'b0;
        end
    end

    // Chain output is the bit leaving the top of the word
    always @(posedge sys_clk) begin
        if (rst) begin
            serial_out <= 1'b0;
        end else begin
            serial_out <= s_chain ? shift_reg[`SDL_WORD_BITS-1] : 1'b0;
        end
    end

    // Latch and its update pulse leave together, so the code never moves silently
    always @(posedge sys_clk) begin
        if (rst) begin
            dac_code <= `SDL_CODE_RST;
            dac_update <= 1'b0;
        end else begin
            dac_code <= latch_reg;
            dac_update <= upd_reg;
        end
    end

    // Queue head register holds its word until the consumer takes it
    always @(posedge sys_clk) begin
        if (rst) begin
            code_data <= `SDL_CODE_RST;
            code_valid <= 1'b0;
        end else if (head_free(code_valid, code_ready)) begin
            code_valid <= fifo_out_valid;
            code_data <= fifo_out_data;
        end
    end

    // Each latch update is queued; a full queue drops the copy, the latch itself still updates
    sdl_fifo #(
        .WIDTH(`SDL_FIFO_WIDTH),
        .DEPTH(`SDL_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .clk(sys_clk),
        .rst(rst),
        .in_valid(upd_reg && fifo_in_ready),
        .in_ready(fifo_in_ready),
        .in_data(latch_reg),
        .out_valid(fifo_out_valid),
        .out_ready(head_free(code_valid, code_ready)),
        .out_data(fifo_out_data)
    );
endmodule // sdl_word_loader
`default_nettype wire

// ---- sdl_wl_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdl_wl_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic frame_n,
    input wire logic latch_load_n,
    input wire logic latch_clear_n,
    input wire logic chain_enable,
    input wire logic serial_out,
    input wire logic [11:0] dac_code,
    input wire logic dac_update,
    input wire logic [11:0] code_data,
    input wire logic code_valid,
    input wire logic code_ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence load_fall;
        latch_load_n ##1 !latch_load_n [*3];
    endsequence
    a_strobe_update: assert property (load_fall |-> ##[1:6] dac_update)
        else $error("no update after strobe");
    a_clear_zero: assert property (!latch_clear_n [*5] |-> dac_code == 12'h000)
        else $error("clear left code");
    a_code_cause: assert property ($changed(dac_code) |-> dac_update)
        else $error("code moved silently");
    a_idle_quiet: assert property ((frame_n && latch_load_n && latch_clear_n) [*6]
        |-> !dac_update) else $error("update while idle");
    a_chain_off: assert property (!chain_enable [*4] |-> !serial_out)
        else $error("serial out without chain");
    a_frame_refuse: assert property ((frame_n && chain_enable) [*6]
        |-> $stable(serial_out)) else $error("shift outside frame");
    a_hold_valid: assert property (code_valid && !code_ready
        |=> code_valid && $stable(code_data)) else $error("queue head lost");
endmodule // sdl_wl_chk
bind sdl_word_loader sdl_wl_chk chk_u (.*);
`default_nettype wire

// ---- sdl_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdl_host (
    output var logic shift_clk = 1'b0,
    output var logic shift_data = 1'b0,
    output var logic frame_n = 1'b1
);
    // Clock idles low, runs only in a frame; data turns on the rise
    task automatic send(input logic [31:0] w, input int n, input bit bytes);
        frame_n = 1'b0;
        #80;
        for (int i = n - 1; i >= 0; i--) begin // Low code bit last
            if (bytes && i == 7) #160; // Byte gap, clock idle, frame kept low
            shift_clk = 1'b1;
            shift_data = w[i]; // Steady across the fall
            #80;
            shift_clk = 1'b0;
            #80;
        end
        frame_n = 1'b1; // Raised after the last bit
        shift_data = ~shift_data; // Released line shows no stale bit
    endtask
endmodule // sdl_host
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: %h not %h", $time, a, b); end end
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic latch_load_n = 1'b1;
    logic latch_clear_n = 1'b1;
    logic chain_enable = 1'b0;
    logic code_ready = 1'b1;
    logic quiet = 1'b0;
    wire logic shift_clk, shift_data, frame_n, serial_out, dac_update, code_valid;
    wire logic [11:0] dac_code, code_data;
    int n_errors = 0;
    int check_count = 0;
    int k;
    logic [11:0] exp_q[$];
    logic [31:0] w;
    logic [11:0] exp_v;
    initial forever #10 sys_clk = ~sys_clk;
    sdl_host host_u (.*);
    sdl_word_loader dut_u (.*);
    task conclude;
        if (n_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task strobe;
        latch_load_n = 1'b0; // 60 ns low
        repeat (3) @(negedge sys_clk);
        latch_load_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask
    task word(input logic [31:0] v, input int n, input bit push, input bit bytes);
        if (push) exp_q.push_back(v[11:0]);
        host_u.send(v, n, bytes);
        repeat (8) @(negedge sys_clk);
    endtask
    // Every update also enters the queue unless it is full, so one watcher covers both
    always @(posedge sys_clk) begin
        if (!rst && !quiet && code_valid === 1'b1 && code_ready) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hxxx;
            `CHK(code_data, exp_v)
        end
    end
    initial begin
        w = $urandom(32'hb76ae10b);
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        w = $urandom;
        word(w, 16, 1'b0, 1'b0);
        `CHK(dac_code, 12'h000)
        exp_q.push_back(w[11:0]);
        strobe();
        `CHK(dac_code, w[11:0])
        chain_enable = 1'b1;
        w = $urandom;
        word(w, 32, 1'b1, 1'b0);
        `CHK(serial_out, w[15])
        strobe(); // Pulse after frame rises, as a one-shot would give
        `CHK(dac_code, w[11:0])
        chain_enable = 1'b0;
        exp_q.push_back(w[11:0]);
        latch_load_n = 1'b0;
        for (k = 0; k < 9; k++) begin
            if (k == 3) code_ready = 1'b0; // Six words, five places: the last is dropped
            w = $urandom;
            word(w, 16, k < 8, k[0]);
            `CHK(dac_code, w[11:0])
        end
        for (k = 0; k < 300 && exp_q.size() > 0; k++) begin
            @(negedge sys_clk);
            code_ready = 1'($urandom);
        end
        `CHK(exp_q.size(), 0)
        `CHK(code_valid, 1'b0)
        code_ready = 1'b1;
        quiet = 1'b1;
        latch_clear_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        `CHK(dac_code, 12'h000)
        `CHK(dac_update, 1'b1)
        latch_clear_n = 1'b1;
        conclude();
    end
endmodule // tb
`default_nettype wire
